// ===== core/clrops_cfg.svh
// Constants for the clear/compare/decrement execution datapath.
// Assumes inclusion by bare name from files under core/.
`ifndef CLROPS_CFG_SVH
`define CLROPS_CFG_SVH

`define DATA_W 8
`define ADDR_W 6
`define ZERO_BYTE 8'h00
`define ONE_BYTE 8'h01
`define FLAG_SET 1'b1
`define DEST_ACC 1'b0
`define DEST_REG 1'b1

`endif

// ===== core/clrops_pkg.sv
// Types for the clear/compare/decrement execution datapath.
// Assumes nothing beyond a SystemVerilog compiler.
package clrops_pkg;
  // One-hot operation select
  typedef enum logic [6:0] {
    op_none_t_v              = 7'b000_0001,
    accumulator_wipe_op      = 7'b000_0010,
    watchdog_clear_op        = 7'b000_0100,
    register_wipe_op         = 7'b000_1000,
    register_invert_op       = 7'b001_0000,
    register_compare_op      = 7'b010_0000,
    register_decrement_op    = 7'b100_0000
  } op_t;

  typedef struct packed {
    logic [7:0] acc;
    logic zero;
    logic carry;
    logic reg_we;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata;
    logic wdt_clr;
    logic presc_clr;
    logic watchdog_expiry_flag;
    logic sleep_entry_flag;
    logic done;
  } exec_state_t;
endpackage

// ===== core/result_eval.sv
// Combinational result and flag evaluation for one operation.
// Assumes operands are valid in the same cycle as the operation select.
`timescale 1ns/1ps
`default_nettype none
`include "clrops_cfg.svh"
module result_eval
  import clrops_pkg::*;
(
  input wire op_t op_i,
  input wire logic [7:0] acc_i,
  input wire logic [7:0] reg_i,
  output logic [7:0] result_o,
  output logic zero_o,
  output logic carry_o
);
  logic [8:0] diff;

  // Nine-bit subtraction keeps the borrow for the compare
  always_comb begin
    diff = {1'b0, reg_i} - {1'b0, acc_i};
    carry_o = ~diff[8];
    case (op_i)
      accumulator_wipe_op: result_o = `ZERO_BYTE;
      register_wipe_op: result_o = `ZERO_BYTE;
      register_invert_op: result_o = ~reg_i;
      register_compare_op: result_o = diff[7:0];
      register_decrement_op: result_o = reg_i - `ONE_BYTE;
      default: result_o = `ZERO_BYTE;
    endcase
    zero_o = (result_o == `ZERO_BYTE);
  end
endmodule
`default_nettype wire

// ===== core/clrops_exec.sv
// Execution stage for six clear/compare/decrement instructions.
// Assumes the core presents one operation per instruction cycle with the
// addressed register's value already read; data memory sits outside.
`timescale 1ns/1ps
`default_nettype none
`include "clrops_cfg.svh"
module clrops_exec
  import clrops_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire op_t op_i,
  input wire logic dest_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic [7:0] reg_rdata_i,
  input wire logic presc_to_wdt_i,
  output logic [7:0] acc_o,
  output logic zero_o,
  output logic carry_o,
  output logic reg_we_o,
  output logic [5:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic wdt_clr_o,
  output logic presc_clr_o,
  output logic watchdog_expiry_flag_o,
  output logic sleep_entry_flag_o,
  output logic done_o
);
  exec_state_t st_ff;
  exec_state_t nxt_st;
  logic [7:0] result;
  logic res_zero;
  logic res_carry;

  result_eval u_eval (
    .op_i(op_i),
    .acc_i(st_ff.acc),
    .reg_i(reg_rdata_i),
    .result_o(result),
    .zero_o(res_zero),
    .carry_o(res_carry)
  );

  // Next state: every operation finishes in the cycle it is presented
  always_comb begin
    nxt_st = st_ff;
    nxt_st.reg_we = 1'b0;
    nxt_st.wdt_clr = 1'b0;
    nxt_st.presc_clr = 1'b0;
    nxt_st.done = (op_i != op_none_t_v);
    nxt_st.reg_addr = reg_addr_i;
    nxt_st.reg_wdata = result;
    case (op_i)
      accumulator_wipe_op: begin
        nxt_st.acc = result;
        nxt_st.zero = `FLAG_SET;
      end
      watchdog_clear_op: begin
        nxt_st.wdt_clr = 1'b1;
        nxt_st.presc_clr = presc_to_wdt_i;
        nxt_st.watchdog_expiry_flag = `FLAG_SET;
        nxt_st.sleep_entry_flag = `FLAG_SET;
      end
      register_wipe_op: begin
        nxt_st.reg_we = 1'b1;
        nxt_st.zero = `FLAG_SET;
      end
      register_invert_op, register_decrement_op: begin
        nxt_st.zero = res_zero;
        // Destination select steers result
        if (dest_i == `DEST_REG) begin
          nxt_st.reg_we = 1'b1;
        end else begin
          nxt_st.acc = result;
        end
      end
      register_compare_op: begin
        // Difference is dropped: only flags move
        nxt_st.zero = res_zero;
        nxt_st.carry = res_carry;
      end
      default: begin
        nxt_st.done = 1'b0;
      end
    endcase
  end

  // State register; status bits reset low until a watchdog clear
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign acc_o = st_ff.acc;
  assign zero_o = st_ff.zero;
  assign carry_o = st_ff.carry;
  assign reg_we_o = st_ff.reg_we;
  assign reg_addr_o = st_ff.reg_addr;
  assign reg_wdata_o = st_ff.reg_wdata;
  assign wdt_clr_o = st_ff.wdt_clr;
  assign presc_clr_o = st_ff.presc_clr;
  assign watchdog_expiry_flag_o = st_ff.watchdog_expiry_flag;
  assign sleep_entry_flag_o = st_ff.sleep_entry_flag;
  assign done_o = st_ff.done;

  // Checks
  property p_acc_wipe;
    @(posedge clock_i) disable iff (rst_i)
      op_i == accumulator_wipe_op |=> acc_o == `ZERO_BYTE && zero_o && !reg_we_o;
  endproperty
  a_acc_wipe: assert property (p_acc_wipe) else $error("acc wipe wrong");

  property p_wdt_presc;
    @(posedge clock_i) disable iff (rst_i)
      op_i == watchdog_clear_op |=> wdt_clr_o && presc_clr_o == $past(presc_to_wdt_i);
  endproperty
  a_wdt_presc: assert property (p_wdt_presc) else $error("watchdog clear wrong");

  property p_wdt_flags;
    @(posedge clock_i) disable iff (rst_i)
      op_i == watchdog_clear_op |=> watchdog_expiry_flag_o && sleep_entry_flag_o && done_o;
  endproperty
  a_wdt_flags: assert property (p_wdt_flags) else $error("status bits not set");

  property p_reg_wipe;
    @(posedge clock_i) disable iff (rst_i)
      op_i == register_wipe_op |=> reg_we_o && reg_wdata_o == `ZERO_BYTE && zero_o
        && reg_addr_o == $past(reg_addr_i);
  endproperty
  a_reg_wipe: assert property (p_reg_wipe) else $error("register wipe wrong");

  property p_invert;
    @(posedge clock_i) disable iff (rst_i)
      op_i == register_invert_op |=> reg_wdata_o == ~$past(reg_rdata_i)
        && zero_o == ($past(reg_rdata_i) == 8'hFF);
  endproperty
  a_invert: assert property (p_invert) else $error("invert wrong");

  property p_dest;
    @(posedge clock_i) disable iff (rst_i)
      (op_i == register_decrement_op || op_i == register_invert_op)
        |=> reg_we_o == $past(dest_i) && ($past(dest_i) || acc_o == reg_wdata_o);
  endproperty
  a_dest: assert property (p_dest) else $error("destination wrong");

  property p_compare;
    @(posedge clock_i) disable iff (rst_i)
      op_i == register_compare_op |=> carry_o == ($past(reg_rdata_i) >= $past(acc_o))
        && zero_o == ($past(reg_rdata_i) == $past(acc_o));
  endproperty
  a_compare: assert property (p_compare) else $error("compare flags wrong");

  property p_cmp_keep;
    @(posedge clock_i) disable iff (rst_i)
      op_i == register_compare_op |=> !reg_we_o && $stable(acc_o);
  endproperty
  a_cmp_keep: assert property (p_cmp_keep) else $error("compare changed data");

  property p_register_decrement_op;
    @(posedge clock_i) disable iff (rst_i)
      op_i == register_decrement_op |=> reg_wdata_o == $past(reg_rdata_i) - 8'h01
        && zero_o == ($past(reg_rdata_i) == 8'h01);
  endproperty
  a_register_decrement_op: assert property (p_register_decrement_op) else $error("decrement wrong");

  // A select that is not one-hot is refused, so only real operations must report done
  property p_one_cycle;
    @(posedge clock_i) disable iff (rst_i)
      $onehot(op_i) && op_i != op_none_t_v |=> done_o;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("not one cycle");

  c_wdt: cover property (@(posedge clock_i) disable iff (rst_i)
    op_i == watchdog_clear_op && presc_to_wdt_i);
  c_cmp_borrow: cover property (@(posedge clock_i) disable iff (rst_i)
    op_i == register_compare_op ##1 !carry_o);
  c_register_decrement_op_zero: cover property (@(posedge clock_i) disable iff (rst_i)
    op_i == register_decrement_op ##1 zero_o);
endmodule
`default_nettype wire

// ===== dv/tb_mcu_clear_compare_decrement_ops.sv
// Self-checking bench for the clear/compare/decrement execution stage.
// Assumes the core/ package and design are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_mcu_clear_compare_decrement_ops
  import clrops_pkg::*;
;
  // One case: inputs, then expected acc, zero/carry/write bits and write data
  typedef struct packed {
    op_t op;
    logic dest;
    logic [7:0] rd;
    logic pre;
    logic [7:0] acc;
    logic [2:0] zcw;
    logic [7:0] wd;
  } row_t;
  logic clock_i;
  logic rst_i;
  op_t op_i;
  logic dest_i;
  logic [5:0] reg_addr_i;
  logic [7:0] reg_rdata_i;
  logic presc_to_wdt_i;
  logic [7:0] acc_o;
  logic zero_o;
  logic carry_o;
  logic reg_we_o;
  logic [5:0] reg_addr_o;
  logic [7:0] reg_wdata_o;
  logic wdt_clr_o;
  logic presc_clr_o;
  logic watchdog_expiry_flag_o;
  logic sleep_entry_flag_o;
  logic done_o;
  int n_errors;
  int cmp_count;
  logic seen_wdt;
  row_t rows [15];

  clrops_exec dut_u (.clock_i(clock_i), .rst_i(rst_i), .op_i(op_i), .dest_i(dest_i),
    .reg_addr_i(reg_addr_i), .reg_rdata_i(reg_rdata_i), .presc_to_wdt_i(presc_to_wdt_i),
    .acc_o(acc_o), .zero_o(zero_o), .carry_o(carry_o), .reg_we_o(reg_we_o),
    .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o), .wdt_clr_o(wdt_clr_o),
    .presc_clr_o(presc_clr_o), .watchdog_expiry_flag_o(watchdog_expiry_flag_o),
    .sleep_entry_flag_o(sleep_entry_flag_o), .done_o(done_o));

  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_byte(what, {7'h00, exp}, {7'h00, got});
  endtask

  // Inputs change just after the edge, so the next edge takes them cleanly
  task automatic drive(input int i);
    op_i <= rows[i].op;
    dest_i <= rows[i].dest;
    reg_rdata_i <= rows[i].rd;
    presc_to_wdt_i <= rows[i].pre;
    reg_addr_i <= 6'h3f - 6'(i);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // Whole run is under 60 cycles; a hang ends the run as a mismatch
  initial begin
    #20000;
    n_errors++;
    results();
  end

  initial begin
    rst_i = 1'b1;
    op_i = op_none_t_v;
    dest_i = 1'b0;
    reg_addr_i = 6'h00;
    reg_rdata_i = 8'h00;
    presc_to_wdt_i = 1'b0;
    n_errors = 0;
    cmp_count = 0;
    seen_wdt = 1'b0;
    // Back-to-back cases; acc and carry carry over from row to row
    rows = '{'{register_decrement_op, 1'h0, 8'h35, 1'h0, 8'h34, 3'h0, 8'h00},
      '{register_compare_op, 1'h0, 8'h34, 1'h0, 8'h34, 3'h6, 8'h00},
      '{register_compare_op, 1'h0, 8'h33, 1'h0, 8'h34, 3'h0, 8'h00},
      '{register_compare_op, 1'h0, 8'hff, 1'h0, 8'h34, 3'h2, 8'h00},
      '{register_invert_op, 1'h1, 8'ha6, 1'h0, 8'h34, 3'h3, 8'h59},
      '{register_invert_op, 1'h0, 8'hff, 1'h0, 8'h00, 3'h6, 8'h00},
      '{register_decrement_op, 1'h0, 8'h00, 1'h0, 8'hff, 3'h2, 8'h00},
      '{accumulator_wipe_op, 1'h0, 8'h77, 1'h0, 8'h00, 3'h6, 8'h00},
      '{register_compare_op, 1'h0, 8'h00, 1'h0, 8'h00, 3'h6, 8'h00},
      '{register_decrement_op, 1'h1, 8'h01, 1'h0, 8'h00, 3'h7, 8'h00},
      '{register_invert_op, 1'h1, 8'h00, 1'h0, 8'h00, 3'h3, 8'hff},
      '{register_wipe_op, 1'h0, 8'h55, 1'h0, 8'h00, 3'h7, 8'h00},
      '{watchdog_clear_op, 1'h0, 8'h00, 1'h1, 8'h00, 3'h6, 8'h00},
      '{watchdog_clear_op, 1'h0, 8'h00, 1'h0, 8'h00, 3'h6, 8'h00},
      '{register_decrement_op, 1'h1, 8'h80, 1'h0, 8'h00, 3'h3, 8'h7f}};
    repeat (20) @(posedge clock_i);
    #1;
    chk_bit("expiry in reset", 1'b0, watchdog_expiry_flag_o);
    chk_bit("done in reset", 1'b0, done_o);
    @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    drive(0);
    for (int i = 0; i < 15; i++) begin
      @(posedge clock_i);
      if (i < 14) begin
        drive(i + 1);
      end else begin
        op_i <= op_none_t_v;
      end
      #1;
      if (rows[i].op == watchdog_clear_op) begin
        seen_wdt = 1'b1;
      end
      chk_byte("acc", rows[i].acc, acc_o);
      chk_bit("zero", rows[i].zcw[2], zero_o);
      chk_bit("carry", rows[i].zcw[1], carry_o);
      chk_bit("write", rows[i].zcw[0], reg_we_o);
      if (rows[i].zcw[0]) begin
        chk_byte("wdata", rows[i].wd, reg_wdata_o);
        chk_byte("addr", {2'h0, 6'h3f - 6'(i)}, {2'h0, reg_addr_o});
      end
      chk_bit("wdt clear", rows[i].op == watchdog_clear_op, wdt_clr_o);
      chk_bit("presc clear", rows[i].op == watchdog_clear_op && rows[i].pre, presc_clr_o);
      chk_bit("expiry", seen_wdt, watchdog_expiry_flag_o);
      chk_bit("sleep", seen_wdt, sleep_entry_flag_o);
      chk_bit("done", 1'b1, done_o);
    end
    // Idle, then a two-hot select that must be ignored
    for (int k = 0; k < 2; k++) begin
      @(posedge clock_i);
      op_i <= (k == 0) ? op_t'(7'h03) : op_none_t_v;
      #1;
      chk_bit("done idle", 1'b0, done_o);
      chk_bit("write idle", 1'b0, reg_we_o);
      chk_byte("acc idle", 8'h00, acc_o);
      chk_bit("zero idle", 1'b0, zero_o);
    end
    // Reset in mid-run clears status, first op right at release
    @(posedge clock_i);
    rst_i <= 1'b1;
    #1;
    chk_bit("expiry reset", 1'b0, watchdog_expiry_flag_o);
    @(posedge clock_i);
    rst_i <= 1'b0;
    op_i <= register_decrement_op;
    dest_i <= 1'b0;
    reg_rdata_i <= 8'h00;
    @(posedge clock_i);
    op_i <= op_none_t_v;
    #1;
    chk_byte("acc after reset", 8'hff, acc_o);
    chk_bit("zero after reset", 1'b0, zero_o);
    results();
  end
endmodule
`default_nettype wire
